//--- src/viu_defs.svh
// Constants of the vectored interrupt unit: offsets, fields, reset values
// Operation
// - Vector returns highest enabled pending request, range 10h to 2Fh.
// - Vector is stable and valid during the core acknowledge read; unit refreshes it every clock, stable only while lines hold still.
// - Trap enable clears on reset and whenever an external request is caught.
// - Software may set trap enable only while the request flag is clear.
// - Pin bit shows the inverted pin, one when asserted; writes ignored.
// - Trap enable lock stays set once written; only reset clears it.
// - While lock is one, trap enable has no influence on forwarding.
// - External trap forwarded when enable or lock is one, else blocked.
// - Low mask, 16 bits, resets FFFFh; bit n enables line n, bit 0 inert.
// - High enable mask, 16 bits, resets FFFFh; bit n enables line n plus 16.
// - Low status shows lines 15 to 1; bit 0 reads zero.
// - High status shows lines 31 to 16.
// - Status shows raw requests regardless of enable masks.
// - Fixed linear priority, line 31 highest.
// - Lines 0 and 24 have no source and never assert.
// - Trap nesting allowed only while lock is one or after enable is set again; maskable nesting left to the core.
// - Vector equals 10h plus line number.
// - Maskable requests are level sensitive.
// - Pending trap status clears on reset and on every read; the code keeps it set when a fresh edge lands in the read cycle.
`ifndef VIU_DEFS_SVH
`define VIU_DEFS_SVH

// Register offsets on the plain register port
`define VIU_ADDR_W        8
`define VIU_OFF_VECTOR    8'h00
`define VIU_OFF_PENDING   8'h02
`define VIU_OFF_TRAPCTL   8'h04
`define VIU_OFF_STAT_LOW  8'h0a
`define VIU_OFF_STAT_HIGH 8'h0c
`define VIU_OFF_EN_LOW    8'h0e
`define VIU_OFF_EN_HIGH   8'h10

// Field positions in the trap control register
`define VIU_TC_EN         0
`define VIU_TC_PIN        1
`define VIU_TC_LOCK       2
// Field position of the external request flag in pending status
`define VIU_PS_EXT        0

// Reset values and vector encoding
`define VIU_EN_RESET      16'hffff
`define VIU_VEC_BASE      8'h10
`define VIU_VEC_TOP       8'h2f
`define VIU_LINE_MASK     32'hfeff_fffe

`endif

//--- src/viu_pkg.sv
// Types of the vectored interrupt unit
package viu_pkg;

  // Whole state of the unit, bar the reset synchroniser, in one record
  typedef struct packed {
    logic        nmiMeta;
    logic        nmiSync;
    logic        nmiPrev;
    logic        trapEn;
    logic        trapLock;
    logic        extFlag;
    logic [15:0] enLow;
    logic [15:0] enHigh;
    logic [7:0]  vector;
    logic        irqReq;
    logic        nmiReq;
    logic [15:0] rdData;
  } viu_state_t;

endpackage

//--- src/viu_top.sv
// Vectored interrupt unit: priority vector, masks, status, external trap
`timescale 1ns/10ps
`default_nettype none
`include "viu_defs.svh"

module viu_top
  import viu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [31:0] irqLine,
  input  wire logic        nmiPin_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  output logic      [7:0]  intVector,
  output logic             irqReq,
  output logic             nmiReq
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rstMeta_n;
  logic rstSync_n;

  // Assert at once, release two clocks after the pin rises
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ==========================================================
  // State
  // ==========================================================
  viu_state_t st;
  viu_state_t next_st;

  logic [31:0] liveLine;
  logic [31:0] enAll;
  logic [31:0] pendLine;
  logic [7:0]  next_vec;
  logic        nmiFall;
  logic        trapOpen;
  logic        wrTrap;
  logic        rdPend;

  // ==========================================================
  // Request conditioning and priority
  // ==========================================================

  // Unconnected lines are forced low so a stray tie cannot fire
  assign liveLine = irqLine & `VIU_LINE_MASK;
  assign enAll    = {st.enHigh, st.enLow};
  // Plain level qualification; a dropped line just stops counting
  assign pendLine = liveLine & enAll;

  // Fixed linear scan, higher line overrides lower; empty gives 10h
  always_comb begin
    next_vec = `VIU_VEC_BASE;
    for (int i = 1; i < 32; i++) begin
      if (pendLine[i]) begin
        next_vec = `VIU_VEC_BASE + 8'(i);
      end
    end
  end

  // Falling edge seen on the synchronised copy only
  assign nmiFall  = st.nmiPrev & ~st.nmiSync;
  // Lock overrides the enable bit entirely
  assign trapOpen = st.trapLock | st.trapEn;
  assign wrTrap   = regWr && (regAddr == `VIU_OFF_TRAPCTL);
  assign rdPend   = regRd && (regAddr == `VIU_OFF_PENDING);

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    next_st = st;

    // Two-stage synchroniser, then an edge history stage
    next_st.nmiMeta = nmiPin_n;
    next_st.nmiSync = st.nmiMeta;
    next_st.nmiPrev = st.nmiSync;

    // Vector refreshed every clock; stable while lines hold still
    next_st.vector = next_vec;
    next_st.irqReq = |pendLine;

    // Trap pulse to the core; trapOpen gating is what restricts nesting here
    next_st.nmiReq = nmiFall && trapOpen;

    // Enable mask writes
    if (regWr && (regAddr == `VIU_OFF_EN_LOW)) begin
      next_st.enLow = regWrData;
    end else if (regWr && (regAddr == `VIU_OFF_EN_HIGH)) begin
      next_st.enHigh = regWrData;
    end

    // Trap control write; pin bit is not storage and is dropped
    if (wrTrap) begin
      if (!regWrData[`VIU_TC_EN]) begin
        next_st.trapEn = 1'b0;
      end else if (!st.extFlag) begin
        next_st.trapEn = 1'b1;
      end
      if (regWrData[`VIU_TC_LOCK]) begin
        next_st.trapLock = 1'b1;
      end
    end

    // Read clears the pending flag, but a fresh edge wins
    if (rdPend) begin
      next_st.extFlag = 1'b0;
    end
    if (nmiFall) begin
      next_st.extFlag = 1'b1;
      next_st.trapEn  = 1'b0;
    end

    // Read data lives for exactly the cycle after the strobe
    next_st.rdData = 16'h0000;
    if (regRd) begin
      if (regAddr == `VIU_OFF_VECTOR) begin
        next_st.rdData = {8'h00, st.vector};
      end else if (regAddr == `VIU_OFF_PENDING) begin
        next_st.rdData[`VIU_PS_EXT] = st.extFlag;
      end else if (regAddr == `VIU_OFF_TRAPCTL) begin
        next_st.rdData[`VIU_TC_EN]   = st.trapEn;
        next_st.rdData[`VIU_TC_PIN]  = ~st.nmiSync;
        next_st.rdData[`VIU_TC_LOCK] = st.trapLock;
      end else if (regAddr == `VIU_OFF_STAT_LOW) begin
        next_st.rdData = liveLine[15:0];
      end else if (regAddr == `VIU_OFF_STAT_HIGH) begin
        next_st.rdData = liveLine[31:16];
      end else if (regAddr == `VIU_OFF_EN_LOW) begin
        next_st.rdData = st.enLow;
      end else if (regAddr == `VIU_OFF_EN_HIGH) begin
        next_st.rdData = st.enHigh;
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================

  // Pin history resets to idle high so reset cannot fake an edge
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st.nmiMeta  <= 1'b1;
      st.nmiSync  <= 1'b1;
      st.nmiPrev  <= 1'b1;
      st.trapEn   <= 1'b0;
      st.trapLock <= 1'b0;
      st.extFlag  <= 1'b0;
      st.enLow    <= `VIU_EN_RESET;
      st.enHigh   <= `VIU_EN_RESET;
      st.vector   <= `VIU_VEC_BASE;
      st.irqReq   <= 1'b0;
      st.nmiReq   <= 1'b0;
      st.rdData   <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  // Every output straight from the state record
  assign regRdData = st.rdData;
  assign intVector = st.vector;
  assign irqReq    = st.irqReq;
  assign nmiReq    = st.nmiReq;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstSync_n);

  // Synchronised falling edge, and a write trying to set enable
  sequence s_fall;
    st.nmiPrev && !st.nmiSync;
  endsequence

  sequence s_setEn;
    wrTrap && regWrData[`VIU_TC_EN];
  endsequence

  // Pin drop as the unit samples it; the first sync flop is left alone
  sequence s_pinDrop;
    nmiPin_n ##1 !nmiPin_n;
  endsequence

  // Register port accesses shared by several checks
  sequence s_rdVec;
    regRd && regAddr == `VIU_OFF_VECTOR;
  endsequence

  sequence s_wrLow;
    regWr && regAddr == `VIU_OFF_EN_LOW;
  endsequence

  sequence s_wrHigh;
    regWr && regAddr == `VIU_OFF_EN_HIGH;
  endsequence

  sequence s_clrEn;
    wrTrap && !regWrData[`VIU_TC_EN];
  endsequence

  sequence s_setLock;
    wrTrap && regWrData[`VIU_TC_LOCK];
  endsequence

  sequence s_rdStatLow;
    regRd && regAddr == `VIU_OFF_STAT_LOW;
  endsequence

  AST_VEC_RANGE: assert property (
    intVector >= `VIU_VEC_BASE && intVector <= `VIU_VEC_TOP)
    else $error("vector out of range");

  AST_VEC_IDLE: assert property (
    !irqReq |-> intVector == `VIU_VEC_BASE)
    else $error("idle vector not 10h");

  AST_IRQ_OUT: assert property (
    ##1 irqReq == |($past(irqLine) & `VIU_LINE_MASK
                    & {$past(st.enHigh), $past(st.enLow)}))
    else $error("request output wrong");

  AST_TOP_WINS: assert property (
    irqLine[31] && st.enHigh[15] |=> intVector == `VIU_VEC_TOP)
    else $error("line 31 did not win");

  AST_LINE24_DEAD: assert property (
    liveLine[24] == 1'b0 && liveLine[0] == 1'b0)
    else $error("reserved line seen");

  AST_LOCK_STICKY: assert property (
    st.trapLock |=> st.trapLock)
    else $error("lock cleared");

  AST_EN_CLEAR: assert property (
    s_fall |=> !st.trapEn && st.extFlag)
    else $error("edge did not clear enable");

  AST_EN_BLOCK: assert property (
    s_setEn and (st.extFlag ##0 1'b1) |=> !st.trapEn)
    else $error("enable set with flag up");

  AST_FWD: assert property (
    s_fall |=> nmiReq == ($past(st.trapEn) || $past(st.trapLock)))
    else $error("trap forwarding wrong");

  AST_PIN_EDGE: assert property (
    s_pinDrop ##2 1'b1 |=> st.extFlag && nmiReq == $past(trapOpen))
    else $error("pin edge lost");

  AST_READ_CLR: assert property (
    rdPend && !nmiFall |=> !st.extFlag)
    else $error("read did not clear flag");

  AST_PIN_READ: assert property (
    regRd && regAddr == `VIU_OFF_TRAPCTL
    |=> regRdData[`VIU_TC_PIN] == !$past(st.nmiSync))
    else $error("pin bit wrong");

  AST_STAT_RAW: assert property (
    regRd && regAddr == `VIU_OFF_STAT_HIGH
    |=> regRdData == ($past(irqLine[31:16]) & 16'hfeff))
    else $error("high status not raw");

  AST_RD_ONCE: assert property (
    !regRd |=> regRdData == 16'h0000)
    else $error("read data without strobe");

  // ==========================================================
  // Trap control, vector, request, mask and status checks
  // ==========================================================
  // Software clear always lands; set only with the flag down
  AST_EN_CLR_SW: assert property (
    s_clrEn |=> !st.trapEn)
    else $error("enable not cleared by write");

  AST_EN_SET: assert property (
    s_setEn ##0 (!st.extFlag && !nmiFall) |=> st.trapEn)
    else $error("enable write refused with flag clear");

  // Lock rises only by a write and never falls
  AST_LOCK_SET: assert property (
    s_setLock |=> st.trapLock)
    else $error("lock write lost");

  AST_LOCK_HOLD: assert property (
    !st.trapLock && !(wrTrap && regWrData[`VIU_TC_LOCK]) |=> !st.trapLock)
    else $error("lock rose without a write");

  // Lock forwards regardless of the enable bit; nothing passes when both are off
  AST_LOCK_FWD: assert property (
    st.trapLock && nmiFall |=> nmiReq)
    else $error("locked trap not forwarded");

  AST_NO_FWD: assert property (
    !st.trapEn && !st.trapLock |=> !nmiReq)
    else $error("trap forwarded while blocked");

  AST_NMI_PULSE: assert property (
    nmiReq |=> !nmiReq)
    else $error("trap pulse longer than one cycle");

  // Flag rises only from a captured edge
  AST_FLAG_SRC: assert property (
    !st.extFlag && !nmiFall |=> !st.extFlag)
    else $error("flag set without an edge");

  AST_PEND_READ: assert property (
    rdPend |=> regRdData == {15'h0, $past(st.extFlag)})
    else $error("pending status read wrong");

  // Vector read returns the value standing on the core side
  AST_VEC_READ: assert property (
    s_rdVec |=> regRdData == {8'h00, $past(intVector)})
    else $error("vector read not the standing value");

  AST_VEC_STABLE: assert property (
    s_rdVec ##0 $stable(pendLine) |=> $stable(intVector))
    else $error("vector moved with lines still");

  // Masks change only by their own write
  AST_EN_LOW_WR: assert property (
    s_wrLow |=> st.enLow == $past(regWrData))
    else $error("low mask write lost");

  AST_EN_HIGH_WR: assert property (
    s_wrHigh |=> st.enHigh == $past(regWrData))
    else $error("high mask write lost");

  AST_EN_LOW_KEEP: assert property (
    !(regWr && regAddr == `VIU_OFF_EN_LOW) |=> $stable(st.enLow))
    else $error("low mask changed without a write");

  AST_EN_HIGH_KEEP: assert property (
    !(regWr && regAddr == `VIU_OFF_EN_HIGH) |=> $stable(st.enHigh))
    else $error("high mask changed without a write");

  // Status shows raw lines, bit 0 always zero
  AST_STAT_LOW: assert property (
    s_rdStatLow |=> regRdData == ($past(irqLine[15:0]) & 16'hfffe))
    else $error("low status not raw");

  // No latching: an empty pending set drops the request next clock
  AST_IRQ_LEVEL: assert property (
    pendLine == 32'h0 |=> !irqReq)
    else $error("request held after lines dropped");

  // One check per line 1 to 31 except 24; the highest pending line names the vector
  for (genvar n = 1; n < 32; n++) begin : g_lineVec
    if (n != 24) begin : g_live
      AST_LINE_VEC: assert property (
        @(posedge clock) disable iff (!rstSync_n)
        pendLine[n] && (pendLine >> (n + 1)) == 32'h0
        |=> intVector == `VIU_VEC_BASE + 8'(n))
        else $error("vector does not match line");
    end
  end

endmodule
`default_nettype wire

//--- testbench/viu_core_model.sv
// Core-side partner: takes every trap pulse, watches the maskable request
`timescale 1ns/10ps
`default_nettype none

module viu_core_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       irqReq,
  input  wire logic [7:0] intVector,
  input  wire logic       nmiReq,
  output logic      [7:0] nmiCount,
  output logic      [7:0] lastVector
);
  // ==========================================================
  // Trap intake and vector capture
  // Every trap is taken, even inside a handler, so no gating here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nmiCount   <= 8'h00;
      lastVector <= 8'h10;
    end else begin
      if (nmiReq) begin
        nmiCount <= nmiCount + 8'h01;
      end
      if (irqReq) begin
        lastVector <= intVector;
      end
    end
  end
endmodule

`default_nettype wire

//--- testbench/vectored_interrupt_unit_bench.sv
// Self-checking bench of the vectored interrupt unit
`timescale 1ns/10ps
`default_nettype none
`include "viu_defs.svh"

module vectored_interrupt_unit_bench;
  logic        clock;
  logic        rst_n;
  logic [31:0] irqLine;
  logic        nmiPin_n;
  logic [7:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdData;
  logic [7:0]  intVector;
  logic        irqReq;
  logic        nmiReq;
  logic [7:0]  nmiCount;
  logic [7:0]  lastVec;
  logic [31:0] lines;
  logic [31:0] en;
  logic [7:0]  base;
  int          n_mismatch;
  int          n_tests;

  viu_top u_dut (.clock(clock), .rst_n(rst_n), .irqLine(irqLine),
    .nmiPin_n(nmiPin_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .intVector(intVector), .irqReq(irqReq), .nmiReq(nmiReq));

  viu_core_model u_core (.clock(clock), .rst_n(rst_n), .irqReq(irqReq),
    .intVector(intVector), .nmiReq(nmiReq), .nmiCount(nmiCount),
    .lastVector(lastVec));

  // ==========================================================
  // Clock and helpers
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Highest enabled line; lines 0 and 24 never count
  function automatic logic [7:0] expVec(logic [31:0] l, logic [31:0] e);
    logic [31:0] a;
    a = l & e & 32'hfeff_fffe;
    expVec = 8'h10;
    for (int i = 1; i < 32; i++) if (a[i]) expVec = 8'h10 + 8'(i);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic busWrite(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWr     <= 1'b0;
  endtask

  // Read data is only valid in the cycle right after the strobe
  task automatic busRead(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd   <= 1'b0;
    #1 chk(regRdData, exp);
  endtask

  // Pin low and high each held well past the synchroniser
  task automatic pinPulse(input logic [7:0] expCount);
    @(posedge clock);
    nmiPin_n <= 1'b0;
    repeat (6) @(posedge clock);
    nmiPin_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk({8'h00, nmiCount}, {8'h00, expCount});
  endtask

  task automatic end_of_test;
    $display("Tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0; irqLine = 32'h0; nmiPin_n = 1'b1; regAddr = 8'h00;
    regWrData = 16'h0; regWr = 1'b0; regRd = 1'b0;
    void'($urandom(56));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    busRead(`VIU_OFF_EN_LOW, 16'hffff);
    busRead(`VIU_OFF_EN_HIGH, 16'hffff);
    busRead(`VIU_OFF_VECTOR, 16'h0010);
    busRead(`VIU_OFF_TRAPCTL, 16'h0000);
    busRead(8'h40, 16'h0000);
    $display("Reset test done");
    // Corner cases first, then random lines and masks
    for (int k = 0; k < 24; k++) begin
      lines = {$urandom};
      en    = {$urandom};
      case (k)
        0: begin lines = 32'h0100_0001; en = 32'hffff_ffff; end
        1: begin lines = 32'hffff_ffff; en = 32'hffff_ffff; end
        2: en = 32'h0000_0000;
        3: begin lines = 32'h8000_4002; en = 32'h7fff_ffff; end
        default: ;
      endcase
      @(posedge clock);
      irqLine <= lines;
      busWrite(`VIU_OFF_EN_LOW, en[15:0]);
      busWrite(`VIU_OFF_EN_HIGH, en[31:16]);
      repeat (2) @(posedge clock);
      #1 chk({8'h00, intVector}, {8'h00, expVec(lines, en)});
      chk({15'h0, irqReq}, {15'h0, |(lines & en & 32'hfeff_fffe)});
      if (|(lines & en & 32'hfeff_fffe)) begin
        chk({8'h00, lastVec}, {8'h00, expVec(lines, en)});
      end
      busRead(`VIU_OFF_VECTOR, {8'h00, expVec(lines, en)});
      busRead(`VIU_OFF_STAT_LOW, {lines[15:1], 1'b0});
      busRead(`VIU_OFF_STAT_HIGH, lines[31:16] & 16'hfeff);
      busRead(`VIU_OFF_EN_LOW, en[15:0]);
    end
    $display("Vector test done");
    irqLine <= 32'h0;
    base = nmiCount;
    busWrite(`VIU_OFF_TRAPCTL, 16'h0001);
    busRead(`VIU_OFF_TRAPCTL, 16'h0001);
    busWrite(`VIU_OFF_TRAPCTL, 16'h0000);
    busRead(`VIU_OFF_TRAPCTL, 16'h0000);
    busWrite(`VIU_OFF_TRAPCTL, 16'h0001);
    @(posedge clock);
    nmiPin_n <= 1'b0;
    repeat (4) @(posedge clock);
    busRead(`VIU_OFF_TRAPCTL, 16'h0002);
    busWrite(`VIU_OFF_TRAPCTL, 16'h0003);
    busRead(`VIU_OFF_TRAPCTL, 16'h0002);
    nmiPin_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk({8'h00, nmiCount}, {8'h00, base + 8'h01});
    busRead(`VIU_OFF_PENDING, 16'h0001);
    busRead(`VIU_OFF_PENDING, 16'h0000);
    pinPulse(base + 8'h01);
    busWrite(`VIU_OFF_TRAPCTL, 16'h0004);
    busWrite(`VIU_OFF_TRAPCTL, 16'h0000);
    busRead(`VIU_OFF_TRAPCTL, 16'h0004);
    pinPulse(base + 8'h02);
    pinPulse(base + 8'h03);
    $display("Trap test done");
    // Reset again in mid-run: lock, flag and masks go back to idle
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    busRead(`VIU_OFF_TRAPCTL, 16'h0000);
    busRead(`VIU_OFF_PENDING, 16'h0000);
    busRead(`VIU_OFF_EN_HIGH, 16'hffff);
    $display("Second reset test done");
    end_of_test();
  end
endmodule

`default_nettype wire
